// file: rtl/miu_top.sv
// maskable interrupt unit: flags, enables, levels, arbitration toward the core
//
// Design decision made here: the Wishbone register port.
module miu_top (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic reset_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [25:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic wb_ack_o,
    output logic [31:0] wb_dat_o,
    // peripheral side
    input wire logic [15:0] periph_req_i,
    input wire logic wdt_overflow_i,
    // core side
    output miu_pkg::miu_core_req_s core_req_o,
    output logic nmi_o,
    output logic wdt_reset_o
);

    // =====================================================
    // helpers
    // =====================================================
    function automatic logic hits(input logic [23:0] word, input logic [23:0] idx);
        hits = (word == idx);
    endfunction : hits

    // byte lanes 0 and 1 carry the 16-bit registers
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] data,
                                           input logic [3:0] sel);
        merge16 = old;
        if (sel[0])
        begin
            merge16[7:0] = data[7:0];
        end
        if (sel[1])
        begin
            merge16[15:8] = data[15:8];
        end
    endfunction : merge16

    // =====================================================
    // state
    // =====================================================
    logic [15:0] flags;
    logic [15:0] enables;
    logic [15:0] control;
    logic [2:0] levels [miu_pkg::SYSTEMS];
    logic ack;
    logic [31:0] rdata;
    miu_pkg::miu_core_req_s core_req;
    logic nmi;
    logic wdt_rst;

    logic [15:0] next_flags;
    logic [15:0] next_enables;
    logic [15:0] next_control;
    logic [2:0] next_levels [miu_pkg::SYSTEMS];
    logic next_ack;
    logic [31:0] next_rdata;
    miu_pkg::miu_core_req_s next_core_req;
    logic next_nmi;
    logic next_wdt_rst;

    logic [23:0] word;
    logic [23:0] lvl_off;
    logic lvl_hit;
    logic [2:0] lvl_reg;
    logic wr;
    logic [15:0] lane_mask;
    logic [15:0] clear_mask;

    assign word = wb_adr_i[25:2];
    assign lvl_off = word - miu_pkg::IDX_LEVEL0;
    // odd offsets inside the level span stay unmapped
    assign lvl_hit = (lvl_off < miu_pkg::LEVEL_REG_SPAN) && !lvl_off[0];
    assign lvl_reg = lvl_off[3:1];
    // writes land on the edge where the master sees ack
    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && ack;
    assign lane_mask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    // =====================================================
    // bus and registers
    // =====================================================
    always_comb
    begin
        // ack drops after one cycle even if the strobe stays up
        next_ack = wb_cyc_i && wb_stb_i && !ack;
        next_enables = enables;
        next_control = control;
        for (int i = 0; i < miu_pkg::SYSTEMS; i++)
        begin
            next_levels[i] = levels[i];
        end
        clear_mask = (wr && hits(word, miu_pkg::IDX_FLAGS)) ?
                     (wb_dat_i[15:0] & lane_mask & miu_pkg::PULSE_SOURCE_MASK) : 16'h0000;
        if (wr)
        begin
            if (hits(word, miu_pkg::IDX_ENABLE))
            begin
                next_enables = merge16(enables, wb_dat_i[15:0], wb_sel_i);
            end
            if (hits(word, miu_pkg::IDX_CONTROL))
            begin
                next_control = merge16(control, wb_dat_i[15:0], wb_sel_i) & miu_pkg::CONTROL_MASK;
            end
            if (lvl_hit && wb_sel_i[0])
            begin
                next_levels[{lvl_reg, 1'b0}] = wb_dat_i[miu_pkg::LEVEL_LO_POS +: miu_pkg::LEVEL_W];
            end
            if (lvl_hit && wb_sel_i[1])
            begin
                next_levels[{lvl_reg, 1'b1}] = wb_dat_i[miu_pkg::LEVEL_HI_POS +: miu_pkg::LEVEL_W];
            end
        end
        // unmapped addresses read zero
        next_rdata = 32'h0000_0000;
        if (hits(word, miu_pkg::IDX_FLAGS))
        begin
            next_rdata = {16'h0000, flags};
        end
        else if (hits(word, miu_pkg::IDX_ENABLE))
        begin
            next_rdata = {16'h0000, enables};
        end
        else if (hits(word, miu_pkg::IDX_CONTROL))
        begin
            next_rdata = {16'h0000, control};
        end
        else if (hits(word, miu_pkg::IDX_VECTOR_BASE))
        begin
            // entries at base plus four times the vector
            next_rdata = {8'h00, miu_pkg::VECTOR_BASE};
        end
        else if (lvl_hit)
        begin
            next_rdata = {16'h0000, 5'h00, levels[{lvl_reg, 1'b1}], 5'h00, levels[{lvl_reg, 1'b0}]};
        end
    end

    // =====================================================
    // flags
    // =====================================================
    // no synchroniser: requests come from logic on this clock
    always_comb
    begin
        for (int i = 0; i < miu_pkg::SYSTEMS; i++)
        begin
            if (miu_pkg::PULSE_SOURCE_MASK[i])
            begin
                next_flags[i] = flags[i] ? (!clear_mask[i] || periph_req_i[i]) : periph_req_i[i];
            end
            else
            begin
                next_flags[i] = periph_req_i[i];
            end
        end
    end

    // =====================================================
    // arbitration toward the core
    // =====================================================
    logic found;
    logic [2:0] best_level;
    logic [3:0] best_idx;

    always_comb
    begin
        found = 1'b0;
        best_level = 3'h0;
        best_idx = 4'h0;
        // strict compare in ascending order keeps lowest vector on ties
        for (int i = 0; i < miu_pkg::SYSTEMS; i++)
        begin
            if (flags[i] && enables[i] && (!found || levels[i] > best_level))
            begin
                found = 1'b1;
                best_level = levels[i];
                best_idx = 4'(i);
            end
        end
        // level and vector follow the winner even while the unit is off
        // request, level and vector together
        // re-evaluated every cycle, loser stays pending
        next_core_req.req = found && control[miu_pkg::CTL_ENABLE_BIT];
        next_core_req.level = found ? best_level : 3'h0;
        next_core_req.vector = found ? (miu_pkg::VECTOR_FIRST + {1'b0, best_idx}) : 5'h00;
        // one route per overflow, the other output stays quiet
        // watchdog routed by software
        next_wdt_rst = wdt_overflow_i && control[miu_pkg::CTL_WDT_RESET_BIT];
        next_nmi = wdt_overflow_i && !control[miu_pkg::CTL_WDT_RESET_BIT];
    end

    // =====================================================
    // registers
    // =====================================================
    // all zero at reset
    always_ff @(posedge core_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            enables <= miu_pkg::ENABLE_RESET;
            control <= miu_pkg::CONTROL_RESET;
            for (int i = 0; i < miu_pkg::SYSTEMS; i++)
            begin
                levels[i] <= miu_pkg::LEVEL_RESET;
            end
            ack <= 1'b0;
            rdata <= 32'h0000_0000;
        end
        else
        begin
            enables <= next_enables;
            control <= next_control;
            for (int i = 0; i < miu_pkg::SYSTEMS; i++)
            begin
                levels[i] <= next_levels[i];
            end
            ack <= next_ack;
            rdata <= next_rdata;
        end
    end

    // flags move on peripheral events, and pulse flags also clear on bus writes to the flag register
    always_ff @(posedge core_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            flags <= miu_pkg::FLAGS_RESET;
        end
        else
        begin
            flags <= next_flags;
        end
    end

    // registered so the core never sees arbitration glitches
    always_ff @(posedge core_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            core_req <= miu_pkg::CORE_REQ_RESET;
            nmi <= 1'b0;
            wdt_rst <= 1'b0;
        end
        else
        begin
            core_req <= next_core_req;
            nmi <= next_nmi;
            wdt_rst <= next_wdt_rst;
        end
    end

    assign wb_ack_o = ack;
    assign wb_dat_o = rdata;
    assign core_req_o = core_req;
    assign nmi_o = nmi;
    assign wdt_reset_o = wdt_rst;

endmodule : miu_top

// file: rtl/miu_pkg.sv
// package: register map, reset values and carrier types of the interrupt unit
package miu_pkg;

    // =====================================================
    // register indices (byte address = 4 * index)
    // =====================================================
    localparam logic [23:0] IDX_FLAGS = 24'h004300;
    localparam logic [23:0] IDX_ENABLE = 24'h004302;
    localparam logic [23:0] IDX_CONTROL = 24'h004304;
    localparam logic [23:0] IDX_LEVEL0 = 24'h004306;
    localparam logic [23:0] IDX_VECTOR_BASE = 24'hffff80;
    localparam logic [23:0] LEVEL_REG_SPAN = 24'h000010;

    // =====================================================
    // field positions
    // =====================================================
    localparam int CTL_ENABLE_BIT = 0;
    localparam int CTL_WDT_RESET_BIT = 1;
    localparam int LEVEL_LO_POS = 0;
    localparam int LEVEL_HI_POS = 8;
    localparam logic [15:0] PULSE_SOURCE_MASK = 16'hff00;
    localparam logic [15:0] CONTROL_MASK = 16'h0003;

    // =====================================================
    // reset values and fixed numbers
    // =====================================================
    localparam logic [15:0] FLAGS_RESET = 16'h0000;
    localparam logic [15:0] ENABLE_RESET = 16'h0000;
    localparam logic [15:0] CONTROL_RESET = 16'h0000;
    localparam logic [2:0] LEVEL_RESET = 3'h0;
    localparam logic [23:0] VECTOR_BASE = 24'h008000;
    localparam logic [4:0] VECTOR_FIRST = 5'h04;
    localparam int SYSTEMS = 16;
    localparam int LEVEL_W = 3;

    // =====================================================
    // carrier toward the core
    // =====================================================
    typedef struct packed {
        logic req;
        logic [2:0] level;
        logic [4:0] vector;
    } miu_core_req_s;

    localparam miu_core_req_s CORE_REQ_RESET = '{req: 1'b0, level: 3'h0, vector: 5'h00};

endpackage : miu_pkg

// file: tb/miu_top_asserts.sv
// checker: port-level assertions of the interrupt unit
module miu_top_asserts (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic reset_i,
    // bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [25:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    // core side
    input wire logic wdt_overflow_i,
    input wire miu_pkg::miu_core_req_s core_req_o,
    input wire logic nmi_o,
    input wire logic wdt_reset_o
);
    default clocking @(posedge core_clk_i);
    endclocking
    default disable iff (reset_i);
    // ==========
    // shadow of enable bit
    // ==========
    logic ctl_en;
    logic next_ctl_en;
    always_comb
    begin
        next_ctl_en = ctl_en;
        if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_adr_i == 26'h0010c10 && wb_sel_i[0])
            next_ctl_en = wb_dat_i[0];
    end
    always_ff @(posedge core_clk_i or posedge reset_i)
        if (reset_i)
            ctl_en <= 1'b0;
        else
            ctl_en <= next_ctl_en;
    // ==========
    // assertions
    // ==========
    vec_range_a: assert property (
        core_req_o.req |-> core_req_o.vector >= 5'h04 && core_req_o.vector <= 5'h13) else $error("vector range");
    base_read_a: assert property (
        wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && wb_adr_i == 26'h3fffe00
        |=> wb_ack_o && wb_dat_o == 32'h00008000) else $error("vector base read");
    ack_reply_a: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
    ack_pulse_a: assert property (
        wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    ack_idle_a: assert property (
        !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("ack without request");
    wdt_route_a: assert property (
        wdt_overflow_i |=> nmi_o != wdt_reset_o) else $error("watchdog not routed");
    wdt_quiet_a: assert property (
        !wdt_overflow_i |=> !nmi_o && !wdt_reset_o) else $error("watchdog spurious");
    enable_gate_a: assert property (
        !ctl_en |=> !core_req_o.req) else $error("request while unit off");
endmodule : miu_top_asserts

// file: tb/miu_periph_model.sv
// peripheral model: level sources hold, pulse sources fire once per cause
module miu_periph_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // causes and requests
    input wire logic [15:0] raise_i,
    output logic [15:0] req_o
);
    logic [15:0] prev;
    always_ff @(posedge clk_i or posedge rst_i)
        if (rst_i)
        begin
            prev <= 16'h0000;
            req_o <= 16'h0000;
        end
        else
        begin
            prev <= raise_i;
            req_o <= {raise_i[15:8] & ~prev[15:8], raise_i[7:0]};
        end
endmodule : miu_periph_model

// file: tb/miu_top_bench.sv
// bench: register, priority and watchdog scenarios of the interrupt unit
module miu_top_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk_i = 1'b0;
    logic reset_i, cyc, stb, we, wdt, ack, nmi, wrst;
    logic [25:0] adr;
    logic [3:0] sel;
    logic [31:0] dat, rdat, got;
    logic [15:0] raise, preq;
    miu_pkg::miu_core_req_s creq;
    int fail_count = 0;
    int samples_checked = 0;
    always #25 core_clk_i = ~core_clk_i;
    miu_top uut (.core_clk_i(core_clk_i), .reset_i(reset_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_ack_o(ack), .wb_dat_o(rdat), .periph_req_i(preq),
        .wdt_overflow_i(wdt), .core_req_o(creq), .nmi_o(nmi), .wdt_reset_o(wrst));
    miu_periph_model periph (.clk_i(core_clk_i), .rst_i(reset_i), .raise_i(raise), .req_o(preq));
    // ==========
    // helpers
    // ==========
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e)
        begin
            fail_count++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task bus(input logic w, input logic [25:0] a, input logic [15:0] d);
        @(posedge core_clk_i);
        {cyc, stb, we, adr, dat, sel} <= {1'b1, 1'b1, w, a, 16'h0000, d, 4'h3};
        do @(posedge core_clk_i); while (ack !== 1'b1);
        got = rdat;
        {cyc, stb, we} <= 3'b000;
    endtask : bus
    task rdchk(input logic [25:0] a, input logic [15:0] e);
        bus(1'b0, a, 16'h0000);
        chk("reg", {16'h0000, e}, got);
    endtask : rdchk
    task tick(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask : tick
    // ==========
    // scenarios
    // ==========
    task t_reset;
        rdchk(26'h0010c00, 16'h0000);
        rdchk(26'h0010c08, 16'h0000);
        rdchk(26'h0010c10, 16'h0000);
        rdchk(26'h3fffe00, 16'h8000);
        rdchk(26'h0010c04, 16'h0000);
        chk("core", 32'h0, {23'h0, creq});
    endtask : t_reset
    task t_flags;
        raise <= 16'h0201;
        tick(4);
        rdchk(26'h0010c00, 16'h0201);
        chk("req", 32'h0, {31'h0, creq.req});
        raise <= 16'h0001;
        bus(1'b1, 26'h0010c00, 16'hffff);
        rdchk(26'h0010c00, 16'h0001);
        raise <= 16'h0000;
        tick(4);
        rdchk(26'h0010c00, 16'h0000);
    endtask : t_flags
    task t_prio;
        bus(1'b1, 26'h0010c08, 16'h0302);
        bus(1'b1, 26'h0010c10, 16'h0001);
        raise <= 16'h0202;
        tick(4);
        chk("core", {23'h0, 1'b1, 3'h0, 5'h05}, {23'h0, creq});
        bus(1'b1, 26'h0010c38, 16'h0300);
        rdchk(26'h0010c38, 16'h0300);
        tick(2);
        chk("core", {23'h0, 1'b1, 3'h3, 5'h0d}, {23'h0, creq});
        rdchk(26'h0010c00, 16'h0202);
        bus(1'b1, 26'h0010c10, 16'h0000);
        tick(2);
        chk("req", 32'h0, {31'h0, creq.req});
        bus(1'b1, 26'h0010c10, 16'h0001);
        tick(2);
        chk("core", {23'h0, 1'b1, 3'h3, 5'h0d}, {23'h0, creq});
        bus(1'b1, 26'h0010c00, 16'h0200);
        tick(2);
        chk("core", {23'h0, 1'b1, 3'h0, 5'h05}, {23'h0, creq});
        raise <= 16'h0000;
        tick(4);
        chk("req", 32'h0, {31'h0, creq.req});
    endtask : t_prio
    task t_wdt;
        for (int r = 0; r < 2; r++)
        begin
            bus(1'b1, 26'h0010c10, 16'(r * 2));
            wdt <= 1'b1;
            @(posedge core_clk_i);
            wdt <= 1'b0;
            @(posedge core_clk_i);
            chk("route", 32'(r == 0 ? 2'b10 : 2'b01), {30'h0, nmi, wrst});
        end
    endtask : t_wdt
    task t_rerst;
        reset_i <= 1'b1;
        tick(2);
        reset_i <= 1'b0;
        rdchk(26'h0010c08, 16'h0000);
        rdchk(26'h0010c10, 16'h0000);
        rdchk(26'h0010c38, 16'h0000);
        chk("core", 32'h0, {23'h0, creq});
    endtask : t_rerst
    task t_race;
        raise <= 16'h0400;
        tick(3);
        raise <= 16'h0000;
        tick(2);
        // new pulse lands on the very edge that clears the flag
        fork
            bus(1'b1, 26'h0010c00, 16'h0400);
            begin
                @(posedge core_clk_i);
                raise <= 16'h0400;
            end
        join
        rdchk(26'h0010c00, 16'h0400);
        raise <= 16'h0000;
        bus(1'b1, 26'h0010c00, 16'h0400);
        rdchk(26'h0010c00, 16'h0000);
    endtask : t_race
    task end_sim;
        $display("checked %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_sim
    initial
    begin
        {reset_i, cyc, stb, we, wdt, adr, sel, dat, raise} <= {1'b1, 4'h0, 26'h0, 4'h0, 32'h0, 16'h0};
        tick(2);
        reset_i <= 1'b0;
        t_reset;
        t_flags;
        t_prio;
        t_rerst;
        t_race;
        t_wdt;
        end_sim;
    end
    initial
    begin
        #100000;
        fail_count++;
        end_sim;
    end
endmodule : miu_top_bench
bind miu_top miu_top_asserts chk_i (.core_clk_i(core_clk_i), .reset_i(reset_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .wdt_overflow_i(wdt_overflow_i), .core_req_o(core_req_o),
    .nmi_o(nmi_o), .wdt_reset_o(wdt_reset_o));
